// [vcpat_arbiter.sv]
// module: vc0 port arbitration table, load engine, table-driven arbiter and ahb-lite slave
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module vcpat_arbiter
   import vcpat_pkg::*;
(
   input wire logic clk, // 10 mhz configuration clock
   input wire logic rst, // synchronous reset, active high
   input wire logic hsel, // ahb slave select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   input wire logic [3:0] egress_port, // this port's own number, same-clock strap
   input wire logic [7:0] port_request, // ingress port requests, same clock
   output logic [31:0] hrdata, // ahb read data
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   output logic [7:0] port_grant, // one-hot grant to ingress ports
   output logic [3:0] current_slot, // low bits of phase index for debug
   output logic table_pending_flag // coherency status
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [VCPAT_WORDS-1:0][31:0] table_words;
      logic [VCPAT_WORDS-1:0][31:0] loaded_words;
      logic [2:0] arbitration_scheme_select;
      logic table_pending_flag;
      logic load_request;
      vcpat_state_t state;
      logic [1:0] copy_idx;
      logic [4:0] phase;
      logic dp_write;
      logic [11:0] dp_addr;
      logic [31:0] hrdata;
      logic [7:0] port_grant;
   } vcpat_regs_t;

   vcpat_regs_t r;
   vcpat_regs_t next_r;

   function automatic logic [3:0] slot_of(input logic [VCPAT_WORDS-1:0][31:0] w, input logic [4:0] idx);
      slot_of = w[idx[4:3]][idx[2:0]*VCPAT_SLOT_W +: VCPAT_SLOT_W];
   endfunction : slot_of

   function automatic logic slot_valid(input logic [3:0] code, input logic [3:0] own);
      slot_valid = (code < 4'(VCPAT_PORTS)) && (code != own);
   endfunction : slot_valid

   function automatic logic uses_table(input logic [2:0] sch);
      uses_table = (sch >= VCPAT_SCHEME_TBL_MIN);
   endfunction : uses_table

   // ----------------------------------------------------------------
   // address phase decode
   // ----------------------------------------------------------------
   logic take;
   logic [11:0] a_off;
   logic [31:0] rd_mux;
   logic tbl_hit;
   logic [1:0] tbl_idx;
   logic [4:0] scan;
   logic found;
   logic [3:0] code;

   assign take = hsel && hready && (htrans == VCPAT_HTRANS_NONSEQ);
   assign a_off = haddr[11:0];

   always_comb begin
      next_r = r;
      rd_mux = 32'h0000_0000;
      tbl_hit = 1'b0;
      tbl_idx = 2'h0;
      scan = 5'h00;
      found = 1'b0;
      code = 4'h0;
      // ----------------------------------------------------------------
      // data phase write commit
      // ----------------------------------------------------------------
      if (r.dp_write) begin
         unique case (r.dp_addr)
            VCPAT_CTRL_OFF: begin
               if (VCPAT_SCHEME_CAP[hwdata[VCPAT_SCHEME_LSB +: VCPAT_SCHEME_W]]) begin
                  next_r.arbitration_scheme_select = hwdata[VCPAT_SCHEME_LSB +: VCPAT_SCHEME_W];
               end
               if (hwdata[VCPAT_LOAD_BIT]) begin
                  next_r.load_request = 1'b1;
               end
            end
            VCPAT_TBL0_OFF, VCPAT_TBL1_OFF, VCPAT_TBL2_OFF, VCPAT_TBL3_OFF: begin
               tbl_hit = 1'b1;
               tbl_idx = r.dp_addr[3:2];
            end
            default: begin
            end
         endcase
         if (tbl_hit) begin
            next_r.table_words[tbl_idx] = hwdata;
         end
      end
      // ----------------------------------------------------------------
      // load engine, one word per cycle
      // ----------------------------------------------------------------
      unique case (r.state)
         VCPAT_IDLE: begin
            if (r.load_request) begin
               next_r.load_request = 1'b0;
               next_r.copy_idx = 2'h0;
               next_r.state = VCPAT_COPY;
            end
         end
         VCPAT_COPY: begin
            next_r.loaded_words[r.copy_idx] = r.table_words[r.copy_idx];
            next_r.copy_idx = r.copy_idx + 2'h1;
            if (r.copy_idx == 2'(VCPAT_WORDS - 1)) begin
               next_r.state = VCPAT_IDLE;
               next_r.table_pending_flag = 1'b0;
            end
         end
         default: begin
            next_r.state = VCPAT_IDLE;
         end
      endcase
      // a table write in the same cycle as completion wins
      if (tbl_hit) begin
         next_r.table_pending_flag = 1'b1;
      end
      // ----------------------------------------------------------------
      // read data for the next data phase
      // ----------------------------------------------------------------
      if (take && !hwrite) begin
         unique case (a_off)
            VCPAT_CTRL_OFF: rd_mux[VCPAT_SCHEME_LSB +: VCPAT_SCHEME_W] = r.arbitration_scheme_select;
            VCPAT_STAT_OFF: rd_mux[VCPAT_PEND_BIT] = r.table_pending_flag;
            VCPAT_TBL0_OFF: rd_mux = r.table_words[0];
            VCPAT_TBL1_OFF: rd_mux = r.table_words[1];
            VCPAT_TBL2_OFF: rd_mux = r.table_words[2];
            VCPAT_TBL3_OFF: rd_mux = r.table_words[3];
            default: rd_mux = 32'h0000_0000;
         endcase
      end
      next_r.hrdata = rd_mux;
      next_r.dp_write = take && hwrite && (hsize == VCPAT_HSIZE_WORD);
      next_r.dp_addr = a_off;
      // ----------------------------------------------------------------
      // arbiter
      // ----------------------------------------------------------------
      // in table schemes, from the current phase find first valid slot, skipping invalid ones at once; else lowest requesting port
      next_r.port_grant = 8'h00;
      if (uses_table(r.arbitration_scheme_select)) begin
         for (int i = 0; i < VCPAT_SLOTS; i++) begin
            scan = r.phase + 5'(i);
            code = slot_of(r.loaded_words, scan);
            if (!found && slot_valid(code, egress_port)) begin
               found = 1'b1;
               next_r.port_grant = 8'h01 << code[2:0];
               next_r.phase = scan + 5'h01;
            end
         end
      end else begin
         next_r.phase = 5'h00;
         for (int i = 0; i < VCPAT_PORTS; i++) begin
            if (!found && port_request[i] && (3'(i) != egress_port[2:0])) begin
               found = 1'b1;
               next_r.port_grant = 8'h01 << i;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
         r.table_words <= {VCPAT_WORDS{VCPAT_TBL_RST}};
         r.loaded_words <= {VCPAT_WORDS{VCPAT_TBL_RST}};
         r.arbitration_scheme_select <= VCPAT_SCHEME_RST;
         r.state <= VCPAT_IDLE;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign hrdata = r.hrdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign port_grant = r.port_grant;
   assign current_slot = r.phase[3:0];
   assign table_pending_flag = r.table_pending_flag;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   // pending flag
   a_pend_set: assert property (@(posedge clk) disable iff (rst)
      r.dp_write && (r.dp_addr == VCPAT_TBL1_OFF) |=> r.table_pending_flag)
      else $error("pending flag not set after table write");
   a_pend_hold: assert property (@(posedge clk) disable iff (rst)
      r.table_pending_flag && !((r.state == VCPAT_COPY) && (r.copy_idx == 2'(VCPAT_WORDS - 1)))
      |=> r.table_pending_flag)
      else $error("pending flag dropped without load");
   a_pend_clear: assert property (@(posedge clk) disable iff (rst)
      $fell(r.table_pending_flag) |-> $past(r.state) == VCPAT_COPY)
      else $error("pending flag cleared outside copy");
   a_copy_last: assert property (@(posedge clk) disable iff (rst)
      (r.state == VCPAT_COPY) && (r.copy_idx == 2'(VCPAT_WORDS - 1))
      |=> (r.state == VCPAT_IDLE) && (!r.table_pending_flag || $past(tbl_hit)))
      else $error("pending flag not cleared at end of copy");
   // ----------------------------------------------------------------
   // load engine assertions
   // ----------------------------------------------------------------
   a_load_start: assert property (@(posedge clk) disable iff (rst)
      (r.state == VCPAT_IDLE) && r.load_request |=> (r.state == VCPAT_COPY))
      else $error("table load did not start");
   a_load_done: assert property (@(posedge clk) disable iff (rst)
      (r.state == VCPAT_IDLE) && r.load_request && !r.dp_write |=> ##4 (r.state == VCPAT_IDLE))
      else $error("table load did not finish in four cycles");
   // ----------------------------------------------------------------
   // register assertions
   // ----------------------------------------------------------------
   a_stat_read: assert property (@(posedge clk) disable iff (rst)
      take && !hwrite && (a_off == VCPAT_STAT_OFF) |=> (r.hrdata[31:17] == 15'h0000) && (r.hrdata[15:0] == 16'h0000))
      else $error("status read shows nonzero reserved bits");
   a_stat_flag: assert property (@(posedge clk) disable iff (rst)
      take && !hwrite && (a_off == VCPAT_STAT_OFF) |=> r.hrdata[VCPAT_PEND_BIT] == $past(r.table_pending_flag))
      else $error("status read does not show pending flag");
   a_ctrl_load: assert property (@(posedge clk) disable iff (rst)
      take && !hwrite && (a_off == VCPAT_CTRL_OFF) |=> !r.hrdata[VCPAT_LOAD_BIT])
      else $error("load bit read back as one");
   a_ctrl_scheme: assert property (@(posedge clk) disable iff (rst)
      take && !hwrite && (a_off == VCPAT_CTRL_OFF)
      |=> r.hrdata[VCPAT_SCHEME_LSB +: VCPAT_SCHEME_W] == $past(r.arbitration_scheme_select))
      else $error("scheme field read back wrong");
   a_tbl_read0: assert property (@(posedge clk) disable iff (rst)
      take && !hwrite && (a_off == VCPAT_TBL0_OFF) |=> r.hrdata == $past(r.table_words[0]))
      else $error("slot word 0 read back wrong");
   a_tbl_store: assert property (@(posedge clk) disable iff (rst)
      r.dp_write && (r.dp_addr == VCPAT_TBL0_OFF) |=> r.table_words[0] == $past(hwdata))
      else $error("slot word 0 not stored");
   a_tbl_store1: assert property (@(posedge clk) disable iff (rst)
      r.dp_write && (r.dp_addr == VCPAT_TBL1_OFF) |=> r.table_words[1] == $past(hwdata))
      else $error("slot word 1 not stored");
   a_tbl_store2: assert property (@(posedge clk) disable iff (rst)
      r.dp_write && (r.dp_addr == VCPAT_TBL2_OFF) |=> r.table_words[2] == $past(hwdata))
      else $error("slot word 2 not stored");
   a_tbl_store3: assert property (@(posedge clk) disable iff (rst)
      r.dp_write && (r.dp_addr == VCPAT_TBL3_OFF) |=> r.table_words[3] == $past(hwdata))
      else $error("slot word 3 not stored");
   // ----------------------------------------------------------------
   // arbiter assertions
   // ----------------------------------------------------------------
   a_grant_valid: assert property (@(posedge clk) disable iff (rst)
      (r.port_grant != 8'h00) |-> $onehot(r.port_grant))
      else $error("grant not one-hot");
   a_skip_egress: assert property (@(posedge clk) disable iff (rst)
      (r.port_grant != 8'h00) && (egress_port < 4'(VCPAT_PORTS)) |-> !r.port_grant[egress_port[2:0]])
      else $error("egress port granted to itself");
   a_scheme_cap: assert property (@(posedge clk) disable iff (rst)
      VCPAT_SCHEME_CAP[r.arbitration_scheme_select])
      else $error("unadvertised scheme selected");
   // ----------------------------------------------------------------
   // cover points
   // ----------------------------------------------------------------
   c_table_write: cover property (@(posedge clk) r.dp_write && (r.dp_addr == VCPAT_TBL2_OFF));
   c_fixed_grant: cover property (@(posedge clk) !uses_table(r.arbitration_scheme_select) && (r.port_grant != 8'h00));
   c_load_done: cover property (@(posedge clk) $fell(r.table_pending_flag));
   c_table_grant: cover property (@(posedge clk) uses_table(r.arbitration_scheme_select) && (r.port_grant != 8'h00));
endmodule : vcpat_arbiter

// [vcpat_pkg.sv]
// package: register map, field positions and arbiter constants for the vc0 port arbitration table
package vcpat_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] VCPAT_CTRL_OFF = 12'h214;
   localparam logic [11:0] VCPAT_STAT_OFF = 12'h218;
   localparam logic [11:0] VCPAT_TBL0_OFF = 12'h240;
   localparam logic [11:0] VCPAT_TBL1_OFF = 12'h244;
   localparam logic [11:0] VCPAT_TBL2_OFF = 12'h248;
   localparam logic [11:0] VCPAT_TBL3_OFF = 12'h24C;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int VCPAT_LOAD_BIT = 16;
   localparam int VCPAT_SCHEME_LSB = 17;
   localparam int VCPAT_SCHEME_W = 3;
   localparam int VCPAT_PEND_BIT = 16;
   localparam int VCPAT_NEG_BIT = 17;
   localparam int VCPAT_SLOT_W = 4;
   localparam int VCPAT_SLOTS = 32;
   localparam int VCPAT_WORDS = 4;
   localparam int VCPAT_PORTS = 8;
   // ----------------------------------------------------------------
   // reset values and scheme codes
   // ----------------------------------------------------------------
   localparam logic [31:0] VCPAT_TBL_RST = 32'h0000_0000;
   localparam logic [2:0] VCPAT_SCHEME_RST = 3'h0;
   localparam logic [2:0] VCPAT_SCHEME_RR = 3'h0;
   // schemes at or above this code use the table (time-based weighted round robin family)
   localparam logic [2:0] VCPAT_SCHEME_TBL_MIN = 3'h1;
   // advertised schemes, one bit per scheme code
   localparam logic [7:0] VCPAT_SCHEME_CAP = 8'h0F;
   localparam logic [3:0] VCPAT_EGRESS_PORT_RST = 4'h0;
   localparam logic [1:0] VCPAT_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] VCPAT_HSIZE_WORD = 3'h2;
   // ----------------------------------------------------------------
   // copy engine states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      VCPAT_IDLE = 2'b00,
      VCPAT_COPY = 2'b01
   } vcpat_state_t;
endpackage : vcpat_pkg

// [vcpat_ingress_model.sv]
// ingress port model: passes want through as requests to the arbiter and counts grants received
`timescale 1ns/1ps
module vcpat_ingress_model (
   input wire logic clk, // 10 mhz clock
   input wire logic rst, // synchronous reset, active high
   input wire logic [7:0] want, // ports with traffic queued
   input wire logic [7:0] port_grant, // grant from the arbiter
   output logic [7:0] port_request, // requests to the arbiter
   output logic [15:0] grant_count // grants seen since reset
);
   // a port keeps requesting while it has traffic queued
   assign port_request = want;
   always_ff @(posedge clk) begin
      if (rst) begin
         grant_count <= 16'h0000;
      end else if (port_grant != 8'h00) begin
         grant_count <= grant_count + 16'h0001;
      end
   end
endmodule : vcpat_ingress_model

// [tb_top.sv]
// testbench: register map, load handshake and arbitration of the vc0 table
`timescale 1ns/1ps
module tb_top;
   import vcpat_pkg::*;
   logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, table_pending_flag;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] egress_port, current_slot;
   logic [7:0] port_request, port_grant, want;
   logic [15:0] grant_count;
   int miscompares, checks;
   assign hready = hreadyout;
   vcpat_arbiter u_vcpat_arbiter (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .egress_port(egress_port),
      .port_request(port_request), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .port_grant(port_grant), .current_slot(current_slot), .table_pending_flag(table_pending_flag));
   vcpat_ingress_model u_vcpat_ingress_model (.clk(clk), .rst(rst), .want(want), .port_grant(port_grant),
      .port_request(port_request), .grant_count(grant_count));
   // ----------------------------------------------------------------
   // checking, bus and closing tasks
   // ----------------------------------------------------------------
   task automatic results;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_ready;
      int n;
      logic seen;
      n = 0;
      do begin
         @(negedge clk);
         seen = hready;
         rd = hrdata;
         @(posedge clk);
         n++;
      end while (seen !== 1'b1 && n < 50);
      if (seen !== 1'b1) begin
         miscompares++;
         results();
      end
   endtask : wait_ready
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      htrans <= VCPAT_HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= VCPAT_HSIZE_WORD;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
   endtask : ahb
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic s_reset_values;
      logic [11:0] offs [6] = '{VCPAT_CTRL_OFF, VCPAT_STAT_OFF, VCPAT_TBL0_OFF, VCPAT_TBL1_OFF,
                                VCPAT_TBL2_OFF, VCPAT_TBL3_OFF};
      foreach (offs[i]) begin
         ahb(1'b0, offs[i], 32'h0000_0000);
         chk(rd, 32'h0000_0000);
         chk({31'h0, hresp}, 32'h0000_0000);
      end
   endtask : s_reset_values
   task automatic s_table_rw;
      // slots 0..7 low first: ports 0,3, code 8, egress 7, ports 1,2, codes F,9
      logic [31:0] w [4] = '{32'h9F21_7830, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
      for (int i = 0; i < 4; i++) ahb(1'b1, VCPAT_TBL0_OFF + 12'(4 * i), w[i]);
      @(negedge clk);
      chk({31'h0, table_pending_flag}, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         ahb(1'b0, VCPAT_TBL0_OFF + 12'(4 * i), 32'h0000_0000);
         chk(rd, w[i]);
      end
      ahb(1'b1, VCPAT_STAT_OFF, 32'hFFFF_FFFF);
      ahb(1'b0, VCPAT_STAT_OFF, 32'h0000_0000);
      chk(rd, 32'h0001_0000);
      ahb(1'b0, 12'h21C, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
   endtask : s_table_rw
   task automatic s_load;
      int n;
      ahb(1'b1, VCPAT_CTRL_OFF, 32'h0003_0000);
      n = 0;
      do begin
         ahb(1'b0, VCPAT_STAT_OFF, 32'h0000_0000);
         n++;
      end while (rd !== 32'h0000_0000 && n < 20);
      chk(rd, 32'h0000_0000);
      ahb(1'b1, VCPAT_CTRL_OFF, 32'h0008_0000);
      ahb(1'b0, VCPAT_CTRL_OFF, 32'h0000_0000);
      chk(rd, 32'h0002_0000);
   endtask : s_load
   task automatic s_table_arb;
      logic [3:0] seq [4] = '{4'h0, 4'h3, 4'h1, 4'h2};
      // phase after granting each of the valid slots 0, 1, 4, 5
      logic [3:0] ph [4] = '{4'h1, 4'h2, 4'h5, 4'h6};
      int k;
      logic [15:0] c0;
      k = 0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      for (int i = 0; i < 4; i++) if (port_grant === 8'(8'h01 << seq[i])) k = i;
      c0 = grant_count;
      for (int i = 0; i < 8; i++) begin
         chk({24'h0, port_grant}, 32'(8'h01 << seq[k]));
         chk({28'h0, current_slot}, {28'h0, ph[k]});
         k = (k + 1) % 4;
         @(negedge clk);
      end
      chk({16'h0, grant_count - c0}, 32'h0000_0008);
   endtask : s_table_arb
   task automatic s_fixed_prio;
      ahb(1'b1, VCPAT_CTRL_OFF, 32'h0000_0000);
      want <= 8'h68;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({24'h0, port_grant}, 32'h0000_0008);
   endtask : s_fixed_prio
   // ----------------------------------------------------------------
   // clock, reset and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      miscompares = 0;
      checks = 0;
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = VCPAT_HSIZE_WORD;
      hwdata = 32'h0000_0000;
      egress_port = 4'h7;
      want = 8'h00;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      s_reset_values();
      s_table_rw();
      s_load();
      s_table_arb();
      s_fixed_prio();
      results();
   end
endmodule : tb_top
